//--- design/rsm_pkg.sv
package rsm_pkg;
  // strap bit positions on the data bus
  localparam int DATA_W          = 16;
  localparam int STRAP_BOOT8_BIT = 0;
  localparam int STRAP_ARB_BIT   = 1;
  localparam int STRAP_FC_BIT    = 2;
  localparam int STRAP_ADDR_LO   = 3;
  localparam int STRAP_ADDR_HI   = 7;
  localparam int STRAP_GP_PORT_E_BIT = 8;
  localparam int STRAP_GP_PORT_F_BIT = 9;
  localparam int STRAP_TEST_BIT  = 11;
  // number of chip selects that can turn into upper address lines
  localparam int ADDR_CS_N       = 5;
  // output clocks from reset release to the first bus cycle
  localparam int FIRST_CYC_CLKS  = 10;
  localparam logic [3:0] FIRST_CYC_CNT = 4'(FIRST_CYC_CLKS);
  // values after reset: straps read as pulled high (defaults)
  localparam logic [DATA_W-1:0] STRAP_RST = 16'hFFFF;
  localparam logic              CFG_RST   = 1'b1;

  // breakpoint handling state
  typedef enum logic [2:0] {
    RSM_BK_IDLE = 3'b001,
    RSM_BK_EXC  = 3'b010,
    RSM_BK_BDM  = 3'b100
  } rsm_bk_state_t;
endpackage : rsm_pkg

//--- design/rsm_reset_strap.sv
`timescale 1ns/1ps
// Functional notes
// - undriven data line reads high, default
// - data0 low gives 8-bit boot port
// - data1/data2 low give arbitration, function codes
// - highest low bit 3..7 sets address lines
// - data8 low gives bus control to port e
// - data9 low gives irq, clock pin port f
// - data11 low enables factory test mode
// - clock pin high selects synthesizer clock
// - boot chip select active at reset release
// - breakpoint low at release sets debug flag
// - both high means later breakpoint takes exception
module rsm_reset_strap
  import rsm_pkg::*;
(
  clk,
  rst_b,
  data_in,
  data_pull_oe,
  clock_mode_pin,
  breakpoint_input_b,
  breakpoint_int_b,
  boot_chip_select_en,
  boot_port_8bit,
  arb_pins_en,
  function_code_en,
  addr_cs_mask,
  gp_port_e_en,
  gp_port_f_en,
  test_mode,
  use_synth_clock,
  background_debug_flag,
  enter_debug,
  start_breakpoint_input_exc,
  first_bus_cycle
);
  input  wire logic                       clk;
  input  wire logic                       rst_b;
  input  wire logic [rsm_pkg::DATA_W-1:0] data_in;
  output logic                            data_pull_oe;
  input  wire logic                       clock_mode_pin;
  input  wire logic                       breakpoint_input_b;
  input  wire logic                       breakpoint_int_b;
  output logic                            boot_chip_select_en;
  output logic                            boot_port_8bit;
  output logic                            arb_pins_en;
  output logic                            function_code_en;
  output logic [rsm_pkg::ADDR_CS_N-1:0]   addr_cs_mask;
  output logic                            gp_port_e_en;
  output logic                            gp_port_f_en;
  output logic                            test_mode;
  output logic                            use_synth_clock;
  output logic                            background_debug_flag;
  output logic                            enter_debug;
  output logic                            start_breakpoint_input_exc;
  output logic                            first_bus_cycle;

  import rsm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_m_q;
  logic       rst_s_q;
  logic       rst_s_dly_q;
  logic [DATA_W-1:0] data_s;
  logic [2:0] pin_s;

  // async assert, synchronous release of the internal reset;
  // every flop past the pin synchronisers resets from rst_s_q
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // data bus straps, through two flops before use
  rsm_sync2 #(
    .W       (DATA_W),
    .RST_VAL (STRAP_RST)
  ) u_sync_data (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (data_in),
    .q     (data_s)
  );

  // clock mode pin and both breakpoint inputs
  rsm_sync2 #(
    .W       (3),
    .RST_VAL (3'h7)
  ) u_sync_pins (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({clock_mode_pin, breakpoint_input_b, breakpoint_int_b}),
    .q     (pin_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // strap capture

  logic          cap_pulse;
  logic [DATA_W-1:0] strap_q;
  logic          clkmode_q;
  logic          breakpoint_input_flag_q;
  logic [ADDR_CS_N-1:0] addr_mask_d;

  // capture fires on the first edge after the internal reset deasserts
  assign cap_pulse = rst_s_q & ~rst_s_dly_q;

  // weak pull-up model: pull enable stays on while in reset
  logic pull_q;

  // delayed reset copy for release edge detection
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      rst_s_dly_q <= 1'b0;
    end else begin
      rst_s_dly_q <= rst_s_q;
    end
  end

  // straps are a plain register loaded once; holding them constant
  // afterwards keeps a late bus glitch from reshaping the pinout
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      strap_q     <= STRAP_RST;
      clkmode_q   <= CFG_RST;
      breakpoint_input_flag_q <= 1'b0;
    end else if (cap_pulse) begin
      strap_q     <= data_s;
      clkmode_q   <= pin_s[2];
      breakpoint_input_flag_q <= ~(pin_s[1] & pin_s[0]);
    end
  end

  // thermometer mask: highest low bit n fills lanes 0..n-3
  always_comb begin
    addr_mask_d = '0;
    for (int i = 0; i < ADDR_CS_N; i++) begin
      if (!strap_q[STRAP_ADDR_LO+i]) begin
        addr_mask_d = ADDR_CS_N'((1 << (i + 1)) - 1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // first bus cycle timer

  logic [3:0] cyc_cnt_q;
  logic       first_q;
  logic       counting;

  assign counting = rst_s_q && (cyc_cnt_q != FIRST_CYC_CNT);

  // counts output clocks after release; bus must be free by the end
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      cyc_cnt_q <= 4'h0;
      first_q   <= 1'b0;
    end else begin
      if (counting) begin
        cyc_cnt_q <= cyc_cnt_q + 4'h1;
      end
      first_q <= rst_s_q && (cyc_cnt_q == FIRST_CYC_CNT - 4'h1);
    end
  end

  // pull-ups drive only while held in reset; pull_q drops on the first edge after the internal reset deasserts, data_pull_oe on the second
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      pull_q <= 1'b1;
    end else begin
      pull_q <= ~rst_s_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // breakpoint handling

  rsm_bk_state_t bk_q;
  rsm_bk_state_t bk_d;
  logic          breakpoint_input_edge;
  logic          breakpoint_input_lvl_q;
  logic          breakpoint_input_lvl;

  assign breakpoint_input_lvl  = ~(pin_s[1] & pin_s[0]);
  assign breakpoint_input_edge = breakpoint_input_lvl & ~breakpoint_input_lvl_q;

  // later assertions route by the captured flag
  always_comb begin
    bk_d = bk_q;
    case (bk_q)
      RSM_BK_IDLE: begin
        if (rst_s_dly_q && breakpoint_input_edge) begin
          bk_d = breakpoint_input_flag_q ? RSM_BK_BDM : RSM_BK_EXC;
        end
      end
      RSM_BK_EXC: bk_d = RSM_BK_IDLE;
      RSM_BK_BDM: bk_d = RSM_BK_IDLE;
      default:    bk_d = RSM_BK_IDLE;
    endcase
  end

  // level history: the assertion seen at release is not a later one
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      bk_q       <= RSM_BK_IDLE;
      breakpoint_input_lvl_q <= 1'b1;
    end else begin
      bk_q       <= bk_d;
      breakpoint_input_lvl_q <= rst_s_q ? breakpoint_input_lvl : 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      boot_chip_select_en   <= 1'b0;
      boot_port_8bit        <= 1'b0;
      arb_pins_en           <= 1'b0;
      function_code_en      <= 1'b0;
      addr_cs_mask          <= '0;
      gp_port_e_en          <= 1'b0;
      gp_port_f_en          <= 1'b0;
      test_mode             <= 1'b0;
      use_synth_clock       <= CFG_RST;
      background_debug_flag <= 1'b0;
      enter_debug           <= 1'b0;
      start_breakpoint_input_exc        <= 1'b0;
      first_bus_cycle       <= 1'b0;
      data_pull_oe          <= 1'b1;
    end else begin
      boot_chip_select_en   <= rst_s_dly_q;
      boot_port_8bit        <= ~strap_q[STRAP_BOOT8_BIT];
      arb_pins_en           <= ~strap_q[STRAP_ARB_BIT];
      function_code_en      <= ~strap_q[STRAP_FC_BIT];
      addr_cs_mask          <= addr_mask_d;
      gp_port_e_en          <= ~strap_q[STRAP_GP_PORT_E_BIT];
      gp_port_f_en          <= ~strap_q[STRAP_GP_PORT_F_BIT];
      test_mode             <= ~strap_q[STRAP_TEST_BIT];
      use_synth_clock       <= clkmode_q;
      background_debug_flag <= breakpoint_input_flag_q;
      enter_debug           <= (bk_d == RSM_BK_BDM);
      start_breakpoint_input_exc        <= (bk_d == RSM_BK_EXC);
      first_bus_cycle       <= first_q;
      data_pull_oe          <= pull_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  a_boot_width: assert property (@(posedge clk) disable iff (!rst_b)
    rst_s_dly_q |-> ##1 (boot_port_8bit == !strap_q[STRAP_BOOT8_BIT]))
    else $error("boot port width does not follow strap");

  a_arb_func: assert property (@(posedge clk) disable iff (!rst_b)
    rst_s_dly_q |-> ##1 (arb_pins_en == !$past(strap_q[STRAP_ARB_BIT])))
    else $error("arbitration pin function wrong");

  a_addr_mask: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_s_dly_q && !strap_q[STRAP_ADDR_HI]) |-> ##1 (addr_cs_mask == 5'h1F))
    else $error("address mask wrong for top strap");

  a_port_e: assert property (@(posedge clk) disable iff (!rst_b)
    rst_s_dly_q |-> ##1 (gp_port_e_en != $past(strap_q[STRAP_GP_PORT_E_BIT])))
    else $error("port e enable wrong");

  a_port_f: assert property (@(posedge clk) disable iff (!rst_b)
    rst_s_dly_q |-> ##1 (gp_port_f_en != $past(strap_q[STRAP_GP_PORT_F_BIT])))
    else $error("port f enable wrong");

  a_test_mode: assert property (@(posedge clk) disable iff (!rst_b)
    cap_pulse |-> ##2 (test_mode == !$past(data_s[STRAP_TEST_BIT], 2)))
    else $error("test mode not from strap");

  a_clock_src: assert property (@(posedge clk) disable iff (!rst_b)
    cap_pulse |-> ##2 (use_synth_clock == $past(pin_s[2], 2)))
    else $error("clock source not from pin");

  a_boot_cs: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_s_q) |-> ##2 boot_chip_select_en)
    else $error("boot chip select not active");

  a_debug_flag: assert property (@(posedge clk) disable iff (!rst_b)
    cap_pulse |-> ##2 (background_debug_flag == !$past(&pin_s[1:0], 2)))
    else $error("debug flag wrong");

  a_breakpoint_input_route: assert property (@(posedge clk) disable iff (!rst_b)
    start_breakpoint_input_exc |-> !background_debug_flag && !enter_debug)
    else $error("exception with debug flag set");

  // the edge after capture is skipped: strap_q loads right before it
  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_s_dly_q && $past(rst_s_dly_q)) |-> $stable(strap_q))
    else $error("straps changed after capture");

  c_boot8: cover property (@(posedge clk) disable iff (!rst_b)
    rst_s_dly_q && boot_port_8bit);
  c_debug: cover property (@(posedge clk) disable iff (!rst_b) enter_debug);
  c_exc: cover property (@(posedge clk) disable iff (!rst_b) start_breakpoint_input_exc);
  c_first: cover property (@(posedge clk) disable iff (!rst_b)
    first_bus_cycle);
endmodule : rsm_reset_strap

//--- design/rsm_sync2.sv
`timescale 1ns/1ps
// two flop synchroniser for pin inputs, parameterised width
module rsm_sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  clk,
  rst_b,
  d,
  q
);
  input  wire logic         clk;
  input  wire logic         rst_b;
  input  wire logic [W-1:0] d;
  output logic      [W-1:0] q;

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rsm_sync2

//--- test/rsm_strap_drv.sv
`timescale 1ns/1ps
// strap conditioning logic on the far side of the data bus
module rsm_strap_drv (
  clk,
  rst_b,
  strap_low,
  cmode,
  data_pull_oe,
  data_bus,
  clock_mode_pin
);
  input  wire logic        clk;
  input  wire logic        rst_b;
  input  wire logic [15:0] strap_low;
  input  wire logic        cmode;
  input  wire logic        data_pull_oe;
  output logic      [15:0] data_bus;
  output logic             clock_mode_pin;

  logic [2:0]  hold_q;
  logic [15:0] tog_q;
  logic [15:0] base;
  logic        drv;

  ////////////////////////////////////////////////////////////////////////////
  // keep driving a few clocks past release, well short of the first cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end

  // floating lines wander once the pull-up is off, so stale values never pass
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tog_q <= 16'hA5A5;
    else tog_q <= ~tog_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // active drive of straps and clock mode pin, released afterwards
  assign drv            = !rst_b || (hold_q != 3'h0);
  assign base           = data_pull_oe ? 16'hFFFF : tog_q;
  assign data_bus       = drv ? (base & ~strap_low) : base;
  assign clock_mode_pin = drv ? cmode : tog_q[0];
endmodule : rsm_strap_drv

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import rsm_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        cmode;
  logic        bk_ext;
  logic        bk_int;
  logic [15:0] strap_low;
  logic [15:0] data_in;
  logic        clock_mode_pin;
  logic        data_pull_oe, boot_chip_select_en, boot_port_8bit;
  logic        arb_pins_en, function_code_en, gp_port_e_en, gp_port_f_en;
  logic        test_mode, use_synth_clock, background_debug_flag;
  logic        enter_debug, start_breakpoint_input_exc, first_bus_cycle;
  logic [4:0]  addr_cs_mask;
  int          failures;
  int          num_checks;
  int          cyc;
  int          fb_at;
  int          fb_n;
  logic [15:0] tbl [10] = '{16'h0000, 16'h0001, 16'h0006, 16'h0008,
                            16'h0010, 16'h0060, 16'h0028, 16'h0080,
                            16'h0300, 16'h0BFF};

  rsm_reset_strap u_rsm_reset_strap (
    .clk(clk), .rst_b(rst_b), .data_in(data_in),
    .data_pull_oe(data_pull_oe), .clock_mode_pin(clock_mode_pin),
    .breakpoint_input_b(bk_ext), .breakpoint_int_b(bk_int),
    .boot_chip_select_en(boot_chip_select_en),
    .boot_port_8bit(boot_port_8bit), .arb_pins_en(arb_pins_en),
    .function_code_en(function_code_en), .addr_cs_mask(addr_cs_mask),
    .gp_port_e_en(gp_port_e_en), .gp_port_f_en(gp_port_f_en),
    .test_mode(test_mode), .use_synth_clock(use_synth_clock),
    .background_debug_flag(background_debug_flag),
    .enter_debug(enter_debug), .start_breakpoint_input_exc(start_breakpoint_input_exc),
    .first_bus_cycle(first_bus_cycle));

  rsm_strap_drv u_rsm_strap_drv (
    .clk(clk), .rst_b(rst_b), .strap_low(strap_low), .cmode(cmode),
    .data_pull_oe(data_pull_oe), .data_bus(data_in),
    .clock_mode_pin(clock_mode_pin));

  ////////////////////////////////////////////////////////////////////////////
  // clock and a monitor that timestamps the first bus cycle marker
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!rst_b) cyc = 0;
    else cyc = cyc + 1;
    if (first_bus_cycle === 1'b1) begin
      fb_at = cyc;
      fb_n  = fb_n + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge clk);
    #2;
  endtask : step

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // highest pulled-low bit of 3..7 wins, lower ones are implied
  function automatic logic [4:0] exp_mask(input logic [15:0] lo);
    logic [4:0] m;
    m = 5'h00;
    for (int k = 0; k < 5; k++) if (lo[3+k]) m = 5'h1F >> (4 - k);
    return m;
  endfunction : exp_mask

  task automatic check_cfg(input logic [15:0] lo, input logic flg);
    chk(boot_chip_select_en, 16'h0001);
    chk(boot_port_8bit, lo[0]);
    chk({arb_pins_en, function_code_en}, {lo[1], lo[2]});
    chk(addr_cs_mask, exp_mask(lo));
    chk(gp_port_e_en, lo[8]);
    chk(gp_port_f_en, lo[9]);
    chk(test_mode, lo[11]);
    chk(use_synth_clock, cmode);
    chk(background_debug_flag, flg);
    chk(data_pull_oe, 16'h0000);
  endtask : check_cfg

  // one reset with a strap set, then a later breakpoint assertion
  task automatic run(input int i);
    logic flg;
    logic dbg;
    logic exc;
    strap_low = tbl[i];
    cmode     = i[0];
    bk_ext    = (i % 3) != 1;
    bk_int    = (i % 3) != 2;
    flg       = !(bk_ext && bk_int);
    fb_n      = 0;
    rst_b     = 1'b0;
    repeat (4) step;
    chk(data_pull_oe, 16'h0001);
    rst_b = 1'b1;
    repeat (20) step;
    check_cfg(tbl[i], flg);
    chk(16'(fb_n), 16'h0001);
    chk((fb_at >= 10) && (fb_at <= 14), 16'h0001);
    repeat (10) step;
    check_cfg(tbl[i], flg);
    bk_ext = 1'b1;
    bk_int = 1'b1;
    repeat (4) step;
    dbg = 1'b0;
    exc = 1'b0;
    if (i[0]) bk_int = 1'b0;
    else bk_ext = 1'b0;
    repeat (6) begin
      step;
      dbg = dbg | enter_debug;
      exc = exc | start_breakpoint_input_exc;
    end
    bk_ext = 1'b1;
    bk_int = 1'b1;
    // let an edge pass before the next run drives the breakpoints again
    step;
    chk(dbg, flg);
    chk(exc, !flg);
  endtask : run

  task automatic print_verdict;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    failures  = 0;
    num_checks = 0;
    fb_n      = 0;
    fb_at     = 0;
    cyc       = 0;
    rst_b     = 1'b0;
    cmode     = 1'b1;
    bk_ext    = 1'b1;
    bk_int    = 1'b1;
    strap_low = 16'h0000;
    repeat (2) step;
    for (int i = 0; i < 10; i++) run(i);
    print_verdict();
  end

  initial begin
    #100us;
    failures++;
    print_verdict();
  end
endmodule : tb
